// >>> rtl/ses_pkg.sv
// package: modes, states, responses, timing counts and carrier structs for the error supervisor
package ses_pkg;

  localparam int unsigned CLK_HZ          = 125_000_000;
  localparam int unsigned SAFE_EXIT_MS    = 200;
  localparam int unsigned INPUT_READY_MS  = 500;
  localparam int unsigned STABILIZE_MS    = 10;
  localparam int unsigned SAFE_EXIT_CYC   = (CLK_HZ / 1000) * SAFE_EXIT_MS;
  localparam int unsigned INPUT_READY_CYC = (CLK_HZ / 1000) * INPUT_READY_MS;
  localparam int unsigned STABILIZE_CYC   = (CLK_HZ / 1000) * STABILIZE_MS;
  localparam int unsigned TIMER_W         = 27;

  localparam logic [31:0] ENC_COUNT_RST   = 32'h0000_0000;
  localparam logic [31:0] POS_RST         = 32'h0000_0000;

  typedef enum logic [3:0] {
    SES_MODE_SERIAL,
    SES_MODE_STEP_DIR,
    SES_MODE_RC_POS,
    SES_MODE_RC_SPEED,
    SES_MODE_AN_POS,
    SES_MODE_AN_SPEED,
    SES_MODE_ENC_POS,
    SES_MODE_ENC_SPEED
  } ses_mode_t;

  typedef enum logic [2:0] {
    SES_ST_RESET,
    SES_ST_DEENERGIZED,
    SES_ST_SOFT_ERROR,
    SES_ST_WAIT_ERR_LINE,
    SES_ST_STARTING_UP,
    SES_ST_NORMAL
  } ses_state_t;

  typedef enum logic [1:0] {
    SES_RSP_DEENERGIZE,
    SES_RSP_HALT_HOLD,
    SES_RSP_DECEL_HOLD,
    SES_RSP_GO_TO_POS
  } ses_rsp_t;

  // one-cycle command pulses from the command decoder
  typedef struct packed {
    logic set_target_pos;
    logic set_target_vel;
    logic halt_hold;
    logic halt_set_pos;
    logic reset;
    logic exit_safe_start;
    logic enter_safe_start;
  } ses_cmd_t;

  // error causes evaluated outside this block
  typedef struct packed {
    logic driver_fault;
    logic deenergized;
    logic soft_error;
  } ses_err_t;

  typedef struct packed {
    logic [31:0] value;
    logic        is_velocity;
  } ses_target_t;

endpackage

// >>> rtl/ses_timer.sv
// one-shot down counter: busy for a programmable number of cycles after start
`timescale 1ns/10ps
module ses_timer
  import ses_pkg::*;
#(
  parameter int unsigned CYCLES = 1
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic start,
  output logic      busy
);

  localparam logic [TIMER_W-1:0] LOAD = TIMER_W'(CYCLES);

  logic [TIMER_W-1:0] cnt_ff;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff <= '0;
    end else if (start) begin
      cnt_ff <= LOAD;
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - TIMER_W'(1);
    end
  end

  assign busy = (cnt_ff != '0);

endmodule

// >>> rtl/ses_edge_sync.sv
// two-flop synchroniser for an asynchronous pin level
`timescale 1ns/10ps
module ses_edge_sync
  import ses_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic din,
  output logic      dout
);

  logic meta_ff;
  logic sync_ff;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule

// >>> rtl/ses_supervisor.sv
// stepper error supervisor: operation state, safe start, shared error line and state effects
`timescale 1ns/10ps
module ses_supervisor
  import ses_pkg::*;
#(
  parameter int unsigned SAFE_EXIT_CYCLES   = SAFE_EXIT_CYC,
  parameter int unsigned INPUT_READY_CYCLES = INPUT_READY_CYC,
  parameter int unsigned STABILIZE_CYCLES   = STABILIZE_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire ses_mode_t   control_mode,
  input  wire ses_rsp_t    soft_err_response,
  input  wire logic        disable_safe_start,
  input  wire logic        ignore_err_line_high,
  input  wire logic        soft_current_enable,
  input  wire logic [31:0] soft_err_position,
  input  wire ses_cmd_t    cmd,
  input  wire logic [31:0] cmd_target,
  input  wire ses_err_t    err_in,
  input  wire logic [31:0] auto_input_scaled,
  input  wire logic        input_readings_ready,
  input  wire logic        motor_moving,
  input  wire logic        step_req,
  input  wire logic        err_line_in,
  output logic             err_line_out,
  output logic             err_line_oe,
  output logic             driver_enable_n,
  output logic             driver_reset_n,
  output logic             step_pulse,
  output logic             encoder_clear,
  output logic             soft_current_active,
  output logic             position_uncertain,
  output logic             halt_stepping,
  output ses_target_t      target,
  output logic             target_load,
  output logic             safe_start_violation,
  output logic             err_line_high,
  output logic             input_not_ready,
  output logic             coil_stabilizing,
  output ses_state_t       op_state
);

  ses_state_t  state_ff;
  ses_state_t  nxt_state;
  logic        err_line_sync;
  logic        ss_force_ff;
  logic        ssv_ff;
  logic        nxt_ssv;
  logic        drive_err_ff;
  logic [1:0]  drv_hist_ff;
  logic        erlh_ff;
  logic        in_wait_ff;
  logic        soft_cur_ff;
  logic        pos_unc_ff;
  logic        halt_ff;
  logic [31:0] input_ff;
  logic        in_is_vel_ff;
  ses_target_t target_ff;
  logic        load_ff;
  logic        ss_exit_busy;
  logic        in_ready_busy;
  logic        stab_busy;
  logic        stab_start;
  logic        restart_evt;
  logic        speed_mode;
  logic        pos_mode;
  logic        rc_an_mode;
  logic        serial_mode;
  logic        hard_err;
  logic        any_err;
  logic        mode_chg;
  ses_mode_t   mode_ff;
  logic        enter_soft;

  assign speed_mode  = (control_mode == SES_MODE_RC_SPEED) || (control_mode == SES_MODE_AN_SPEED)
                    || (control_mode == SES_MODE_ENC_SPEED);
  assign pos_mode    = (control_mode == SES_MODE_RC_POS) || (control_mode == SES_MODE_AN_POS)
                    || (control_mode == SES_MODE_ENC_POS);
  assign rc_an_mode  = (control_mode == SES_MODE_RC_POS) || (control_mode == SES_MODE_RC_SPEED)
                    || (control_mode == SES_MODE_AN_POS) || (control_mode == SES_MODE_AN_SPEED);
  assign serial_mode = (control_mode == SES_MODE_SERIAL);

  ses_edge_sync u_err_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .din      (err_line_in),
    .dout     (err_line_sync)
  );

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= SES_MODE_SERIAL;
    end else begin
      mode_ff <= control_mode;
    end
  end

  assign mode_chg = (mode_ff != control_mode);

  // the first cycle out of reset counts as startup, like a reset command
  logic boot_ff;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      boot_ff <= 1'b1;
    end else begin
      boot_ff <= 1'b0;
    end
  end

  assign restart_evt = boot_ff || cmd.reset || mode_chg;

  ses_timer #(.CYCLES(SAFE_EXIT_CYCLES)) u_ss_exit (
    .core_clk (core_clk),
    .resetn   (resetn),
    .start    (cmd.exit_safe_start),
    .busy     (ss_exit_busy)
  );

  ses_timer #(.CYCLES(INPUT_READY_CYCLES)) u_in_ready (
    .core_clk (core_clk),
    .resetn   (resetn),
    .start    (restart_evt),
    .busy     (in_ready_busy)
  );

  ses_timer #(.CYCLES(STABILIZE_CYCLES)) u_stab (
    .core_clk (core_clk),
    .resetn   (resetn),
    .start    (stab_start),
    .busy     (stab_busy)
  );

  // leaving the soft current limit, or leaving driver reset, restarts stabilising
  assign stab_start = (soft_cur_ff && !(soft_current_enable && enter_soft))
                   || (state_ff == SES_ST_RESET && nxt_state != SES_ST_RESET);

  // the wait ends on ready readings or on the timeout, whichever comes first
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      in_wait_ff <= 1'b1;
    end else if (restart_evt) begin
      in_wait_ff <= 1'b1;
    end else if (input_readings_ready || !in_ready_busy) begin
      in_wait_ff <= 1'b0;
    end
  end

  // the restart cycle itself counts, so a mode change never looks like a real exit
  assign input_not_ready  = (in_wait_ff || restart_evt) && rc_an_mode;
  assign coil_stabilizing = stab_busy;

  // enter command latches until one evaluation has seen it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ss_force_ff <= 1'b0;
    end else begin
      ss_force_ff <= cmd.enter_safe_start && !disable_safe_start;
    end
  end

  always_comb begin
    nxt_ssv = 1'b0;
    // a set bit counts as not normal, since it is what holds the state out of normal
    if (speed_mode) begin
      nxt_ssv = ((state_ff != SES_ST_NORMAL) || ssv_ff) && (input_ff != '0);
    end else if (serial_mode) begin
      nxt_ssv = ((state_ff != SES_ST_NORMAL) || ssv_ff) && !ss_exit_busy;
    end
    if (ss_force_ff) begin
      nxt_ssv = 1'b1;
    end
    if (disable_safe_start) begin
      nxt_ssv = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ssv_ff <= 1'b0;
    end else begin
      ssv_ff <= nxt_ssv;
    end
  end

  assign safe_start_violation = ssv_ff;

  assign hard_err = err_in.driver_fault;
  assign any_err  = hard_err || err_in.deenergized || err_in.soft_error || ssv_ff
                 || input_not_ready || coil_stabilizing;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      drive_err_ff <= 1'b0;
      drv_hist_ff  <= 2'h0;
    end else begin
      drive_err_ff <= any_err;
      drv_hist_ff  <= {drv_hist_ff[0], drive_err_ff};
    end
  end

  // line-high flag looks only at the released line, so own drive never trips it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      erlh_ff <= 1'b0;
    end else begin
      // own drive still echoes through the synchroniser for two cycles after release
      erlh_ff <= !ignore_err_line_high && !drive_err_ff && (drv_hist_ff == 2'h0)
              && err_line_sync;
    end
  end

  assign err_line_high = erlh_ff;
  assign err_line_out  = drive_err_ff;
  assign err_line_oe   = drive_err_ff;

  always_comb begin
    nxt_state = SES_ST_NORMAL;
    if (hard_err || cmd.reset) begin
      nxt_state = SES_ST_RESET;
    end else if (err_in.deenergized) begin
      nxt_state = SES_ST_DEENERGIZED;
    end else if (err_in.soft_error || ssv_ff || input_not_ready) begin
      nxt_state = SES_ST_SOFT_ERROR;
    end else if (erlh_ff) begin
      nxt_state = SES_ST_WAIT_ERR_LINE;
    end else if (coil_stabilizing || soft_cur_ff || state_ff == SES_ST_RESET) begin
      nxt_state = SES_ST_STARTING_UP;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= SES_ST_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign op_state   = state_ff;
  assign enter_soft = (nxt_state == SES_ST_SOFT_ERROR) || (nxt_state == SES_ST_WAIT_ERR_LINE);

  assign driver_enable_n = (state_ff == SES_ST_RESET) || (state_ff == SES_ST_DEENERGIZED)
                        || (halt_ff && soft_err_response == SES_RSP_DEENERGIZE
                            && state_ff != SES_ST_NORMAL && state_ff != SES_ST_STARTING_UP);
  // energized in normal and starting up; soft states keep holding torque unless the deenergize response fired on the exit from normal, which disables the driver
  assign driver_reset_n  = (state_ff != SES_ST_RESET);
  assign encoder_clear   = (state_ff == SES_ST_RESET);
  assign step_pulse      = step_req && !driver_enable_n && !halt_ff;

  // soft limit waits for standstill, so a moving rotor is never starved mid-decel
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      soft_cur_ff <= 1'b0;
    end else if (!(soft_current_enable && enter_soft)) begin
      soft_cur_ff <= 1'b0;
    end else if (!motor_moving) begin
      soft_cur_ff <= 1'b1;
    end
  end

  assign soft_current_active = soft_cur_ff;

  // serial mode holds its input across errors; other modes follow the source
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      input_ff     <= POS_RST;
      in_is_vel_ff <= 1'b0;
    end else if (serial_mode) begin
      if (cmd.set_target_pos || cmd.halt_set_pos) begin
        input_ff     <= cmd_target;
        in_is_vel_ff <= 1'b0;
      end else if (cmd.set_target_vel) begin
        input_ff     <= cmd_target;
        in_is_vel_ff <= 1'b1;
      end else if (cmd.halt_hold || cmd.reset) begin
        input_ff     <= POS_RST;
        in_is_vel_ff <= 1'b1;
      end
    end else begin
      input_ff     <= auto_input_scaled;
      in_is_vel_ff <= speed_mode;
    end
  end

  // response fires on a real exit from normal only; a restart cycle never counts as one
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      target_ff  <= '0;
      load_ff    <= 1'b0;
      pos_unc_ff <= 1'b1;
      halt_ff    <= 1'b0;
    end else begin
      load_ff <= 1'b0;
      if (state_ff == SES_ST_NORMAL && enter_soft && !restart_evt) begin
        unique case (soft_err_response)
          SES_RSP_DEENERGIZE: begin
            pos_unc_ff <= 1'b1;
            halt_ff    <= 1'b1;
          end
          SES_RSP_HALT_HOLD: begin
            pos_unc_ff <= 1'b1;
            halt_ff    <= 1'b1;
          end
          SES_RSP_DECEL_HOLD: begin
            target_ff <= '{value: 32'h0000_0000, is_velocity: 1'b1};
            load_ff   <= 1'b1;
          end
          SES_RSP_GO_TO_POS: begin
            target_ff <= '{value: soft_err_position, is_velocity: 1'b0};
            load_ff   <= 1'b1;
          end
        endcase
      end else if (nxt_state == SES_ST_NORMAL) begin
        halt_ff <= 1'b0;
        if (state_ff != SES_ST_NORMAL) begin
          pos_unc_ff <= 1'b0;
        end
        target_ff <= '{value: input_ff, is_velocity: in_is_vel_ff};
        load_ff   <= 1'b1;
      end else if (state_ff == SES_ST_RESET) begin
        pos_unc_ff <= 1'b1;
        halt_ff    <= 1'b0;
      end
    end
  end

  assign target             = target_ff;
  assign target_load        = load_ff;
  assign position_uncertain = pos_unc_ff;
  assign halt_stepping      = halt_ff;

endmodule

// >>> dv/ses_supervisor_props.sv
// checker: port-level relations of the error supervisor
`timescale 1ns/10ps
module ses_supervisor_props
  import ses_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire ses_mode_t   control_mode,
  input wire ses_rsp_t    soft_err_response,
  input wire logic [31:0] soft_err_position,
  input wire logic        disable_safe_start,
  input wire logic        ignore_err_line_high,
  input wire ses_err_t    err_in,
  input wire logic        err_line_out,
  input wire logic        err_line_oe,
  input wire logic        driver_enable_n,
  input wire logic        driver_reset_n,
  input wire logic        step_pulse,
  input wire logic        encoder_clear,
  input wire ses_target_t target,
  input wire logic        target_load,
  input wire logic        safe_start_violation,
  input wire logic        err_line_high,
  input wire ses_state_t  op_state
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_left_normal;
    (op_state == SES_ST_NORMAL && $stable(control_mode)) ##1
    (op_state == SES_ST_SOFT_ERROR || op_state == SES_ST_WAIT_ERR_LINE);
  endsequence
  sequence s_left_reset;
    (op_state == SES_ST_RESET) ##1 (op_state != SES_ST_RESET);
  endsequence

  a_disabled_no_steps: assert property ((op_state == SES_ST_RESET ||
    op_state == SES_ST_DEENERGIZED) |-> driver_enable_n && !step_pulse)
    else $error("driver enabled or stepping while disabled");
  a_reset_holds_driver: assert property (op_state == SES_ST_RESET |->
    !driver_reset_n && encoder_clear)
    else $error("reset state not holding driver or count");
  a_disable_no_ssv: assert property (disable_safe_start[*3] |-> !safe_start_violation)
    else $error("safe start violation while disabled");
  a_err_drives_line: assert property ((err_in != 3'h0)[*3] |-> err_line_oe && err_line_out)
    else $error("error present but line not driven");
  a_ignore_line_flag: assert property (ignore_err_line_high[*3] |-> !err_line_high)
    else $error("line high flag while ignored");
  a_self_drive_flag: assert property (err_line_oe[*4] |-> !err_line_high)
    else $error("line high flag while self driving");
  a_energize_normal: assert property ((op_state == SES_ST_NORMAL ||
    op_state == SES_ST_STARTING_UP) |-> !driver_enable_n)
    else $error("driver disabled in normal or startup");
  a_load_from_normal: assert property (target_load |->
    (op_state == SES_ST_NORMAL) || ($past(op_state) == SES_ST_NORMAL &&
    op_state inside {SES_ST_SOFT_ERROR, SES_ST_WAIT_ERR_LINE}))
    else $error("target loaded outside normal exit");
  a_decel_response: assert property (s_left_normal ##0 soft_err_response == SES_RSP_DECEL_HOLD
    |-> target_load && target.is_velocity && target.value == 32'h0)
    else $error("decelerate response target wrong");
  a_goto_response: assert property (s_left_normal ##0 soft_err_response == SES_RSP_GO_TO_POS
    |-> target_load && !target.is_velocity && target.value == soft_err_position)
    else $error("go to position response target wrong");
  a_stabilize_block: assert property (s_left_reset |-> (op_state != SES_ST_NORMAL)[*8])
    else $error("normal entered while coil current stabilizing");
endmodule

bind ses_supervisor ses_supervisor_props ses_supervisor_props_i (.*);

// >>> dv/ses_drv_model.sv
// far side: shared pulled-down error line with a peer, and a driver that flags stray steps
`timescale 1ns/10ps
module ses_drv_model (
  input  wire logic  core_clk,
  input  wire logic  resetn,
  input  wire logic  err_line_out,
  input  wire logic  err_line_oe,
  input  wire logic  peer_drive,
  input  wire logic  driver_enable_n,
  input  wire logic  driver_reset_n,
  input  wire logic  step_pulse,
  output logic       err_line_in,
  output logic [7:0] bad_steps
);
  // pulled low when released; any party driving high wins the wire
  assign err_line_in = (err_line_oe & err_line_out) | peer_drive;
  // a step into a disabled or held driver would move the indexer by surprise
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bad_steps <= 8'h00;
    end else if (step_pulse && (driver_enable_n || !driver_reset_n)) begin
      bad_steps <= bad_steps + 8'h01;
    end
  end
endmodule

// >>> dv/tb.sv
// testbench: walks the supervisor through its states except deenergized and compares port values
`timescale 1ns/10ps
module tb;
  import ses_pkg::*;
  logic        core_clk, resetn, disable_safe_start, ignore_err_line_high;
  logic        soft_current_enable, input_readings_ready, motor_moving;
  logic        step_req = 1'b0;
  logic        err_line_in, peer_drive, err_line_out, err_line_oe, driver_enable_n;
  logic        driver_reset_n, step_pulse, encoder_clear, soft_current_active;
  logic        position_uncertain, halt_stepping, target_load, safe_start_violation;
  logic        err_line_high, input_not_ready, coil_stabilizing;
  logic [7:0]  bad_steps;
  logic [31:0] auto_input_scaled;
  logic [31:0] soft_err_position = 32'h0000_0777;
  logic [31:0] cmd_target = 32'h0000_1234;
  ses_mode_t   control_mode;
  ses_rsp_t    soft_err_response;
  ses_cmd_t    cmd;
  ses_err_t    err_in;
  ses_target_t target;
  ses_state_t  op_state;
  int          error_cnt, n_tests;

  // short counts keep the run brief; expectations follow these values
  ses_supervisor #(.SAFE_EXIT_CYCLES(20), .INPUT_READY_CYCLES(50),
    .STABILIZE_CYCLES(10)) ses_supervisor_i (.*);
  ses_drv_model ses_drv_model_i (.*);

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) step_req <= ~step_req;

  task test_done();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(string nm, logic [32:0] e, logic [32:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task pulse(logic [6:0] c);
    @(posedge core_clk);
    cmd <= ses_cmd_t'(c);
    @(posedge core_clk);
    cmd <= '0;
    #1;
  endtask
  // bounded wait for a state; running out ends the run
  task wst(ses_state_t s);
    int i;
    i = 0;
    while (op_state !== s && i < 400) begin
      @(posedge core_clk);
      #1;
      i++;
    end
    n_tests++;
    if (i >= 400) begin
      error_cnt++;
      $display("[FAIL] state expected %0d seen %0d", s, op_state);
      test_done();
    end
  endtask
  task tend(string nm);
    $display("test %s done, mismatches so far %0d", nm, error_cnt);
  endtask

  initial begin
    resetn = 1'b0;
    control_mode = SES_MODE_SERIAL;
    soft_err_response = SES_RSP_DECEL_HOLD;
    disable_safe_start = 1'b0;
    ignore_err_line_high = 1'b0;
    soft_current_enable = 1'b0;
    input_readings_ready = 1'b1;
    motor_moving = 1'b0;
    peer_drive = 1'b0;
    auto_input_scaled = 32'h0;
    cmd = '0;
    err_in = '0;
    error_cnt = 0;
    n_tests = 0;
    cyc(5);
    chk("driver_reset_n", 0, driver_reset_n);
    @(posedge core_clk);
    resetn <= 1'b1;
    cyc(4);
    chk("ssv", 1, safe_start_violation);
    pulse(7'h02);
    wst(SES_ST_NORMAL);
    chk("driver_enable_n", 0, driver_enable_n);
    tend("boot");
    // every soft error response, each followed by a recovery
    for (int r = 0; r < 4; r++) begin
      @(posedge core_clk);
      soft_err_response <= ses_rsp_t'(r);
      err_in <= 3'h1;
      wst(SES_ST_SOFT_ERROR);
      cyc(2);
      chk("err_line_oe", 1, err_line_oe);
      if (r < 2) chk("uncertain", 1, position_uncertain);
      if (r < 2) chk("halt", 1, halt_stepping);
      if (r == 0) chk("driver_enable_n", 1, driver_enable_n);
      if (r == 1) chk("driver_enable_n", 0, driver_enable_n);
      if (r == 2) chk("target", {32'h0, 1'b1}, target);
      if (r == 3) chk("target", {soft_err_position, 1'b0}, target);
      @(posedge core_clk);
      err_in <= 3'h0;
      pulse(7'h02);
      wst(SES_ST_NORMAL);
      cyc(3);
      chk("err_line_oe", 0, err_line_oe);
    end
    tend("responses");
    @(posedge core_clk);
    disable_safe_start <= 1'b1;
    peer_drive <= 1'b1;
    wst(SES_ST_WAIT_ERR_LINE);
    chk("err_line_high", 1, err_line_high);
    chk("err_line_oe", 0, err_line_oe);
    @(posedge core_clk);
    ignore_err_line_high <= 1'b1;
    cyc(4);
    chk("err_line_high", 0, err_line_high);
    wst(SES_ST_NORMAL);
    @(posedge core_clk);
    peer_drive <= 1'b0;
    cyc(3);
    @(posedge core_clk);
    ignore_err_line_high <= 1'b0;
    pulse(7'h01);
    cyc(2);
    chk("ssv", 0, safe_start_violation);
    @(posedge core_clk);
    disable_safe_start <= 1'b0;
    pulse(7'h01);
    cyc(1);
    chk("ssv", 1, safe_start_violation);
    pulse(7'h02);
    wst(SES_ST_NORMAL);
    @(posedge core_clk);
    control_mode <= SES_MODE_ENC_POS;
    cyc(3);
    wst(SES_ST_NORMAL);
    pulse(7'h01);
    cyc(1);
    chk("ssv", 1, safe_start_violation);
    wst(SES_ST_NORMAL);
    tend("line and safe start");
    @(posedge core_clk);
    control_mode <= SES_MODE_ENC_SPEED;
    auto_input_scaled <= 32'h5;
    err_in <= 3'h1;
    wst(SES_ST_SOFT_ERROR);
    cyc(3);
    chk("ssv", 1, safe_start_violation);
    @(posedge core_clk);
    err_in <= 3'h0;
    cyc(5);
    chk("state", SES_ST_SOFT_ERROR, op_state);
    @(posedge core_clk);
    auto_input_scaled <= 32'h0;
    wst(SES_ST_NORMAL);
    @(posedge core_clk);
    auto_input_scaled <= 32'h7;
    cyc(3);
    chk("target", {32'h7, 1'b1}, target);
    @(posedge core_clk);
    control_mode <= SES_MODE_RC_SPEED;
    auto_input_scaled <= 32'h0;
    input_readings_ready <= 1'b0;
    cyc(5);
    chk("input_not_ready", 1, input_not_ready);
    chk("state", SES_ST_SOFT_ERROR, op_state);
    @(posedge core_clk);
    input_readings_ready <= 1'b1;
    wst(SES_ST_NORMAL);
    tend("input modes");
    @(posedge core_clk);
    control_mode <= SES_MODE_SERIAL;
    cyc(3);
    pulse(7'h02);
    wst(SES_ST_NORMAL);
    pulse(7'h40);
    cyc(3);
    chk("target", {cmd_target, 1'b0}, target);
    @(posedge core_clk);
    auto_input_scaled <= 32'h9;
    cyc(3);
    chk("target", {cmd_target, 1'b0}, target);
    @(posedge core_clk);
    soft_current_enable <= 1'b1;
    motor_moving <= 1'b1;
    err_in <= 3'h1;
    wst(SES_ST_SOFT_ERROR);
    cyc(3);
    chk("soft_current", 0, soft_current_active);
    @(posedge core_clk);
    motor_moving <= 1'b0;
    cyc(3);
    chk("soft_current", 1, soft_current_active);
    @(posedge core_clk);
    err_in <= 3'h0;
    pulse(7'h02);
    wst(SES_ST_STARTING_UP);
    chk("coil_stabilizing", 1, coil_stabilizing);
    wst(SES_ST_NORMAL);
    @(posedge core_clk);
    err_in <= 3'h4;
    wst(SES_ST_RESET);
    chk("driver_reset_n", 0, driver_reset_n);
    chk("encoder_clear", 1, encoder_clear);
    chk("driver_enable_n", 1, driver_enable_n);
    chk("bad_steps", 0, bad_steps);
    tend("serial, current and fault");
    test_done();
  end
endmodule
